//--- psp_block_matrix.sv
// Blocking matrix model routing system signals to the stage
`timescale 1ns/10ps
`default_nettype none
module psp_block_matrix (
   input wire logic [3:0] sysSig,
   input wire logic [3:0] routeSel,
   output logic matrixBlock
);
   assign matrixBlock = |(sysSig & routeSel);
endmodule
`default_nettype wire

//--- psp_map.svh
// Constants of the protection stage pick-up block
`ifndef PSP_MAP_SVH
`define PSP_MAP_SVH
`define PSP_MAG_W 16
`define PSP_RESET_PCT 97
`define PSP_PCT_FULL 100
`define PSP_DLY_W 24
`define PSP_FAULT_W 4
`define PSP_BLOCK_LEAD_MS 5
`define PSP_CLK_HZ 10000000
`define PSP_BLOCK_LEAD_CYC ((`PSP_BLOCK_LEAD_MS * `PSP_CLK_HZ) / 1000)
`endif

//--- psp_pkg.sv
// Types of the protection stage pick-up block
package psp_pkg;
   typedef enum logic [1:0] {
      PSP_IDLE = 2'b00,
      PSP_START = 2'b01,
      PSP_INHIB = 2'b10,
      PSP_TRIP = 2'b11
   } psp_state_t;
endpackage

//--- psp_stage.sv
// Pick-up, blocking and definite-time front end of one protection stage
// Function
// - Pick-up asserts when the measured value passes beyond the set level (over or under).
// - Pick-up releases only once the value returns past 97 % of the set level.
// - Blocking is sampled at the start of each program cycle and held for that cycle.
// - Blocking comes from a dedicated output of the blocking matrix.
// - Pick-up without blocking raises start and begins operate timing.
// - Pick-up with blocking raises the inhibited flag and does no timing or trip.
// - Blocking arriving after start clears start and runs release handling as on pick-up reset.
// - Each blocking of a picked-up stage emits a display event and a stamped event with values and fault type.
// - A zero delay trips together with start; otherwise trip follows after the delay.
`timescale 1ns/10ps
`default_nettype none
`include "psp_map.svh"
module psp_stage
   import psp_pkg::*;
#(
   parameter int MAG_W = `PSP_MAG_W,
   parameter int DLY_W = `PSP_DLY_W,
   parameter int FAULT_W = `PSP_FAULT_W
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cycleStart,
   input wire logic underMode,
   input wire logic [MAG_W-1:0] measMag,
   input wire logic [MAG_W-1:0] pickupSet,
   input wire logic [DLY_W-1:0] operDelay,
   input wire logic [FAULT_W-1:0] faultType,
   input wire logic [31:0] timeStamp,
   input wire logic matrixBlock,
   output logic pickupActive,
   output logic startInd,
   output logic stageInhibitedFlag,
   output logic tripInd,
   output logic releaseEvt,
   output logic dispEvt,
   output logic blockEvt,
   output logic [MAG_W-1:0] blockEvtMag,
   output logic [FAULT_W-1:0] blockEvtFault,
   output logic [31:0] blockEvtTime
);
   localparam int PW = MAG_W + 8;
   logic blockSync;
   logic blockCyc_ff;
   logic nxt_blockCyc;
   logic pickup_ff;
   logic nxt_pickup;
   psp_state_t state_ff;
   psp_state_t nxt_state;
   logic [DLY_W-1:0] tmr_ff;
   logic [DLY_W-1:0] nxt_tmr;
   logic release_ff;
   logic nxt_release;
   logic disp_ff;
   logic nxt_disp;
   logic evt_ff;
   logic nxt_evt;
   logic [MAG_W-1:0] evtMag_ff;
   logic [MAG_W-1:0] nxt_evtMag;
   logic [FAULT_W-1:0] evtFault_ff;
   logic [FAULT_W-1:0] nxt_evtFault;
   logic [31:0] evtTime_ff;
   logic [31:0] nxt_evtTime;
   logic [PW-1:0] measScaled;
   logic [PW-1:0] setScaled;
   logic [PW-1:0] resetScaled;
   logic overPick;
   logic overHold;
   logic pickNow;
   logic delayDone;

   // Scale by 100 so the 97 % threshold is exact
   function automatic logic [PW-1:0] pct(input logic [MAG_W-1:0] v, input logic [7:0] p);
      pct = PW'(v) * PW'(p);
   endfunction

   // True when a lies past b in the direction that the mode selects
   function automatic logic beyond(input logic under, input logic [PW-1:0] a,
      input logic [PW-1:0] b);
      beyond = under ? (a < b) : (a > b);
   endfunction

   // Instant trip when no operate delay is set, timed start otherwise
   function automatic psp_state_t armState(input logic [DLY_W-1:0] dly);
      armState = (dly == '0) ? PSP_TRIP : PSP_START;
   endfunction

   // Blocking from the matrix output, synchronised into this domain
   // Two clocks of latency, well inside the lead the far side must give
   psp_sync u_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .asyncIn(matrixBlock),
      .syncOut(blockSync)
   );

   always_comb begin
      measScaled = pct(measMag, 8'(`PSP_PCT_FULL));
      setScaled = pct(pickupSet, 8'(`PSP_PCT_FULL));
      resetScaled = pct(pickupSet, 8'(`PSP_RESET_PCT));
      // Over mode: pick at > set, hold while > 97 % of set; under mode: pick at < set, hold while < 97 % of set
      overPick = beyond(underMode, measScaled, setScaled);
      overHold = beyond(underMode, measScaled, resetScaled);
      pickNow = pickup_ff ? overHold : overPick;
      // Pick-up and block are latched only on the program-cycle strobe
      nxt_pickup = cycleStart ? pickNow : pickup_ff;
      nxt_blockCyc = cycleStart ? blockSync : blockCyc_ff;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         blockCyc_ff <= 1'b0;
         pickup_ff <= 1'b0;
      end else begin
         blockCyc_ff <= nxt_blockCyc;
         pickup_ff <= nxt_pickup;
      end
   end

   // Decisions run once per program cycle on the latched pick-up and block
   // Count after this cycle reaches the set delay
   assign delayDone = ((tmr_ff + DLY_W'(1)) >= operDelay);

   always_comb begin
      nxt_state = state_ff;
      nxt_tmr = tmr_ff;
      nxt_release = 1'b0;
      nxt_disp = 1'b0;
      nxt_evt = 1'b0;
      nxt_evtMag = evtMag_ff;
      nxt_evtFault = evtFault_ff;
      nxt_evtTime = evtTime_ff;
      if (cycleStart) begin
         case (state_ff)
            PSP_IDLE: begin
               // Pick-up while blocked: inhibit and snapshot for the recorder
               if (pickNow && nxt_blockCyc) begin
                  nxt_state = PSP_INHIB;
                  nxt_disp = 1'b1;
                  nxt_evt = 1'b1;
                  nxt_evtMag = measMag;
                  nxt_evtFault = faultType;
                  nxt_evtTime = timeStamp;
               end else if (pickNow) begin
                  nxt_tmr = '0;
                  nxt_state = armState(operDelay);
               end
            end
            PSP_START, PSP_TRIP: begin
               if (!pickNow) begin
                  nxt_state = PSP_IDLE;
                  nxt_release = 1'b1;
               end else if (nxt_blockCyc) begin
                  // Late block ends start exactly as a pick-up reset would
                  nxt_state = PSP_INHIB;
                  nxt_release = 1'b1;
                  nxt_disp = 1'b1;
                  nxt_evt = 1'b1;
                  nxt_evtMag = measMag;
                  nxt_evtFault = faultType;
                  nxt_evtTime = timeStamp;
               end else if (state_ff == PSP_START) begin
                  // Only start counts; trip holds until pick-up reset or block
                  nxt_tmr = tmr_ff + DLY_W'(1);
                  if (delayDone) begin
                     nxt_state = PSP_TRIP;
                  end
               end
            end
            PSP_INHIB: begin
               // No timing while inhibited; clears with pick-up
               if (!pickNow) begin
                  nxt_state = PSP_IDLE;
               end else if (!nxt_blockCyc) begin
                  // Block dropped with pick-up still present: start afresh
                  nxt_tmr = '0;
                  nxt_state = armState(operDelay);
               end
            end
            default: begin
               nxt_state = PSP_IDLE;
            end
         endcase
      end
   end

   // Event pulses last one clock; their data stands until the next block
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= PSP_IDLE;
         tmr_ff <= '0;
         release_ff <= 1'b0;
         disp_ff <= 1'b0;
         evt_ff <= 1'b0;
         evtMag_ff <= '0;
         evtFault_ff <= '0;
         evtTime_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         tmr_ff <= nxt_tmr;
         release_ff <= nxt_release;
         disp_ff <= nxt_disp;
         evt_ff <= nxt_evt;
         evtMag_ff <= nxt_evtMag;
         evtFault_ff <= nxt_evtFault;
         evtTime_ff <= nxt_evtTime;
      end
   end

   assign pickupActive = pickup_ff;
   // Trip is a start that has run its delay, so start stays high with it
   assign startInd = (state_ff == PSP_START) || (state_ff == PSP_TRIP);
   assign stageInhibitedFlag = (state_ff == PSP_INHIB);
   assign tripInd = (state_ff == PSP_TRIP);
   assign releaseEvt = release_ff;
   assign dispEvt = disp_ff;
   assign blockEvt = evt_ff;
   assign blockEvtMag = evtMag_ff;
   assign blockEvtFault = evtFault_ff;
   assign blockEvtTime = evtTime_ff;
endmodule
`default_nettype wire

//--- psp_stage_chk_sva.sv
// Port assertions for the protection stage pick-up block
`timescale 1ns/10ps
`default_nettype none
module psp_stage_chk (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic cycleStart,
   input wire logic [23:0] operDelay,
   input wire logic pickupActive,
   input wire logic startInd,
   input wire logic stageInhibitedFlag,
   input wire logic tripInd,
   input wire logic releaseEvt,
   input wire logic dispEvt,
   input wire logic blockEvt
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   AST_EXCL:
      assert property (!(startInd && stageInhibitedFlag)) else $error("start and inhibit");
   AST_HOLD:
      assert property (!$past(cycleStart) |-> $stable({startInd, stageInhibitedFlag, tripInd}))
         else $error("moved without strobe");
   AST_PICK:
      assert property ($rose(pickupActive) |-> $past(cycleStart)) else $error("pick off cycle");
   AST_START:
      assert property ($rose(startInd) |-> pickupActive && !stageInhibitedFlag)
         else $error("bad start");
   AST_EVT:
      assert property ($rose(stageInhibitedFlag) |-> dispEvt && blockEvt) else $error("no event");
   AST_NOTRIP:
      assert property (stageInhibitedFlag |-> !tripInd) else $error("trip while inhibited");
   AST_REL:
      assert property ($fell(startInd) |-> releaseEvt) else $error("no release");
   AST_ZERO:
      assert property ($rose(startInd) && $past(operDelay) == 24'h000000 |-> tripInd)
         else $error("no instant trip");
endmodule
bind psp_stage psp_stage_chk chk (
   .core_clk(core_clk),
   .arst_n(arst_n),
   .cycleStart(cycleStart),
   .operDelay(operDelay),
   .pickupActive(pickupActive),
   .startInd(startInd),
   .stageInhibitedFlag(stageInhibitedFlag),
   .tripInd(tripInd),
   .releaseEvt(releaseEvt),
   .dispEvt(dispEvt),
   .blockEvt(blockEvt)
);
`default_nettype wire

//--- psp_sync.sv
// Two-stage synchroniser for the blocking input
`timescale 1ns/10ps
`default_nettype none
module psp_sync (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic asyncIn,
   output logic syncOut
);
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;
   always_comb begin
      nxt_meta = asyncIn;
      nxt_sync = meta_ff;
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end
   assign syncOut = sync_ff;
endmodule
`default_nettype wire

//--- test_protection_stage_pickup_block.sv
// Self-checking bench of the protection stage pick-up block
`timescale 1ns/10ps
`default_nettype none
`include "psp_map.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_protection_stage_pickup_block;
   localparam logic [15:0] SET = 16'h03e8;
   localparam logic [15:0] HOLD = 16'(SET * `PSP_RESET_PCT / `PSP_PCT_FULL + 1);
   logic core_clk = 0, arst_n = 0, cycleStart = 0, underMode = 0, matrixBlock, csSeen = 0;
   logic pu, st, inh, tr, rel, dsp, blk;
   logic [15:0] measMag = 0, mExp, bMag, setLvl = SET;
   logic [23:0] operDelay = 24'h000002;
   logic [3:0] faultType = 0, sysSig = 0, fExp, bFault;
   logic [31:0] timeStamp = 0, rs = 32'h00001974, tExp, bTime;
   logic [6:0] q[$];
   logic [6:0] ev;
   int num_errors = 0, cmp_count = 0, cyc = 0;
   always #50 core_clk = ~core_clk;
   psp_block_matrix mtx (.sysSig(sysSig), .routeSel(4'h4), .matrixBlock(matrixBlock));
   psp_stage dut (.core_clk(core_clk), .arst_n(arst_n), .cycleStart(cycleStart),
      .underMode(underMode), .measMag(measMag), .pickupSet(setLvl), .operDelay(operDelay),
      .faultType(faultType), .timeStamp(timeStamp), .matrixBlock(matrixBlock),
      .pickupActive(pu), .startInd(st), .stageInhibitedFlag(inh), .tripInd(tr),
      .releaseEvt(rel), .dispEvt(dsp), .blockEvt(blk), .blockEvtMag(bMag),
      .blockEvtFault(bFault), .blockEvtTime(bTime));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction
   task final_report;
      if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Expected {pick, start, inhibit, trip, release, display, block} after one program cycle
   task pc(input logic [15:0] m, input logic b, input logic [6:0] e);
      rs = xs(rs);
      sysSig <= (rs[3:0] & 4'hb) | {1'b0, b, 2'h0};
      measMag <= m;
      faultType <= rs[7:4];
      timeStamp <= rs;
      mExp = m;
      fExp = rs[7:4];
      tExp = rs;
      repeat (3) @(posedge core_clk);
      cycleStart <= 1'b1;
      q.push_back(e);
      @(posedge core_clk);
      cycleStart <= 1'b0;
      @(posedge core_clk);
   endtask
   always @(posedge core_clk) csSeen <= cycleStart;
   always @(negedge core_clk) if (csSeen) begin
      ev = q.pop_front();
      `CHK("state", ev, {pu, st, inh, tr, rel, dsp, blk});
      if (blk === 1'b1) begin
         `CHK("evtMag", mExp, bMag);
         `CHK("evtFault", fExp, bFault);
         `CHK("evtTime", tExp, bTime);
      end
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         final_report;
      end
   end
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      pc(HOLD, 0, 7'h00);
      pc(SET + 16'h0001, 0, 7'h60);
      pc(HOLD, 0, 7'h60);
      pc(HOLD, 0, 7'h68);
      pc(HOLD - 16'h0001, 0, 7'h04);
      // Blocking raised well ahead of the delay end
      pc(16'h05dc, 1, 7'h53);
      repeat (3) pc(16'h05dc, 1, 7'h50);
      pc(16'h05dc, 0, 7'h60);
      pc(16'h05dc, 1, 7'h57);
      pc(16'h0000, 0, 7'h00);
      operDelay <= 24'h000000;
      pc(16'h05dc, 0, 7'h68);
      pc(16'h0000, 0, 7'h04);
      underMode <= 1'b1;
      pc(16'h0064, 0, 7'h68);
      pc(16'h07d0, 0, 7'h04);
      // Hysteresis follows a changed set level
      underMode <= 1'b0;
      setLvl <= 16'h0064;
      pc(16'h0065, 0, 7'h68);
      pc(16'h0062, 0, 7'h68);
      pc(16'h0061, 0, 7'h04);
      final_report;
   end
endmodule
`default_nettype wire
